// ==== hdl/indirect_data_addressing.sv ====
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/100ps

// How it works
// - Plain alias accesses memory at the second pointer, pointer unchanged.
// - Post-increment alias uses the pointer, then adds one.
// - Post-decrement alias uses the pointer, then subtracts one.
// - Pre-increment alias adds one first, then uses the new value.
// - Offset alias uses pointer plus the working register as address.
// - Aliases hold no storage; every access goes to the memory byte at its effective address.
// - Second pointer high byte keeps four low bits; upper bits read zero.
// - Second pointer low byte is a full eight-bit register.
// - Bank select keeps four low bits, cleared by reset.
module indirect_data_addressing (
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  input  wire logic [3:0]                 reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic [7:0]                      reg_rdata,
  input  wire logic [7:0]                 work_reg,
  output indirect_addr_pkg::mem_req_s     mem_req,
  input  wire logic [7:0]                 mem_rdata,
  output logic [3:0]                      bank_sel,
  output logic [11:0]                     pointer_two
);

  logic [11:0] ptr_reg;
  logic [11:0] ptr_next;
  logic [7:0]  ptr1_reg;
  logic [3:0]  bank_reg;
  logic        alias_hit;
  logic        alias_rd_reg;
  logic [7:0]  plain_rdata_reg;
  logic [11:0] eff_addr;
  logic [3:0]  rd_addr_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Alias decode and effective address.

  always_comb begin
    alias_hit = 1'b1;
    eff_addr  = ptr_reg;
    ptr_next  = ptr_reg;
    case (reg_addr)
      indirect_addr_pkg::OFF_PLAIN_ALIAS: begin
        eff_addr = ptr_reg;
      end
      indirect_addr_pkg::OFF_POSTINC_ALIAS: begin
        eff_addr = ptr_reg;
        ptr_next = ptr_reg + 12'h001;
      end
      indirect_addr_pkg::OFF_POSTDEC_ALIAS: begin
        eff_addr = ptr_reg;
        ptr_next = ptr_reg - 12'h001;
      end
      indirect_addr_pkg::OFF_PREINC_ALIAS: begin
        eff_addr = ptr_reg + 12'h001;
        ptr_next = ptr_reg + 12'h001;
      end
      indirect_addr_pkg::OFF_OFFSET_ALIAS: begin
        // The working register acts as an unsigned offset; the sum wraps.
        eff_addr = ptr_reg + {4'h0, work_reg};
      end
      default: begin
        alias_hit = 1'b0;
      end
    endcase
  end

  // Aliases are passed straight to memory; nothing is stored here.
  always_comb begin
    mem_req.rd    = reg_rd & alias_hit;
    mem_req.wr    = reg_wr & alias_hit;
    mem_req.addr  = eff_addr;
    mem_req.wdata = reg_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Second pointer, first pointer low byte and bank select.

  // The pointer reset value is undefined in the part; zero is used so that
  // simulation stays free of unknowns.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ptr_reg <= {indirect_addr_pkg::BANK_RESET, indirect_addr_pkg::POINTER_RESET};
    end else if (reg_wr && reg_addr == indirect_addr_pkg::OFF_POINTER_TWO_HI) begin
      ptr_reg[11:8] <= reg_wdata[3:0];
    end else if (reg_wr && reg_addr == indirect_addr_pkg::OFF_POINTER_TWO_LO) begin
      ptr_reg[7:0] <= reg_wdata;
    end else if ((reg_wr || reg_rd) && alias_hit) begin
      ptr_reg <= ptr_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ptr1_reg <= indirect_addr_pkg::POINTER_RESET;
    end else if (reg_wr && reg_addr == indirect_addr_pkg::OFF_POINTER_ONE_LOW) begin
      ptr1_reg <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bank_reg <= indirect_addr_pkg::BANK_RESET;
    end else if (reg_wr && reg_addr == indirect_addr_pkg::OFF_BANK_SELECT) begin
      bank_reg <= reg_wdata[3:0];
    end
  end

  assign bank_sel    = bank_reg;
  assign pointer_two = ptr_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Read-back, one cycle after the strobe.

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      alias_rd_reg <= 1'b0;
      rd_addr_reg  <= 4'h0;
      plain_rdata_reg <= 8'h00;
    end else begin
      alias_rd_reg <= reg_rd & alias_hit;
      rd_addr_reg  <= reg_addr;
      if (reg_rd) begin
        case (reg_addr)
          indirect_addr_pkg::OFF_POINTER_ONE_LOW: plain_rdata_reg <= ptr1_reg;
          indirect_addr_pkg::OFF_BANK_SELECT:     plain_rdata_reg <= {4'h0, bank_reg};
          indirect_addr_pkg::OFF_POINTER_TWO_HI:  plain_rdata_reg <= {4'h0, ptr_reg[11:8]};
          indirect_addr_pkg::OFF_POINTER_TWO_LO:  plain_rdata_reg <= ptr_reg[7:0];
          default:                                plain_rdata_reg <= 8'h00;
        endcase
      end else begin
        plain_rdata_reg <= 8'h00;
      end
    end
  end

  // Memory answers one cycle after the request, so alias reads pass it through.
  assign reg_rdata = alias_rd_reg ? mem_rdata : plain_rdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  // Every check except a_bank_reset is disabled while reset is high, so the first edge after
  // release never compares against values sampled during reset.
  // Pointer checks look one cycle ahead because the pointer is registered,
  // while address checks look at the same cycle because the request is
  // combinational.

  a_postinc_step: assert property (
    @(posedge sys_clk) disable iff (srst)
    (reg_rd && reg_addr == indirect_addr_pkg::OFF_POSTINC_ALIAS)
      |=> ptr_reg == $past(ptr_reg) + 12'h001)
    else $error("post-increment did not step the pointer");

  a_postinc_wstep: assert property (
    @(posedge sys_clk) disable iff (srst)
    (reg_wr && reg_addr == indirect_addr_pkg::OFF_POSTINC_ALIAS)
      |=> ptr_reg == $past(ptr_reg) + 12'h001)
    else $error("post-increment write did not step the pointer");

  a_postinc_addr: assert property (
    @(posedge sys_clk) disable iff (srst)
    ((mem_req.rd || mem_req.wr) && reg_addr == indirect_addr_pkg::OFF_POSTINC_ALIAS)
      |-> mem_req.addr == ptr_reg)
    else $error("post-increment address wrong");

  a_postdec_step: assert property (
    @(posedge sys_clk) disable iff (srst)
    (reg_wr && reg_addr == indirect_addr_pkg::OFF_POSTDEC_ALIAS)
      |=> ptr_reg == $past(ptr_reg) - 12'h001)
    else $error("post-decrement did not step the pointer");

  a_postdec_rstep: assert property (
    @(posedge sys_clk) disable iff (srst)
    (reg_rd && reg_addr == indirect_addr_pkg::OFF_POSTDEC_ALIAS)
      |=> ptr_reg == $past(ptr_reg) - 12'h001)
    else $error("post-decrement read did not step the pointer");

  a_postdec_addr: assert property (
    @(posedge sys_clk) disable iff (srst)
    ((mem_req.rd || mem_req.wr) && reg_addr == indirect_addr_pkg::OFF_POSTDEC_ALIAS)
      |-> mem_req.addr == ptr_reg)
    else $error("post-decrement address wrong");

  // The pre-increment address is checked against the pointer before the
  // step and the stored pointer one cycle later, so both halves must agree.
  a_preinc_addr: assert property (
    @(posedge sys_clk) disable iff (srst)
    (mem_req.rd && reg_addr == indirect_addr_pkg::OFF_PREINC_ALIAS)
      |-> mem_req.addr == ptr_reg + 12'h001 ##1 ptr_reg == $past(ptr_reg) + 12'h001)
    else $error("pre-increment address wrong");

  a_preinc_waddr: assert property (
    @(posedge sys_clk) disable iff (srst)
    (mem_req.wr && reg_addr == indirect_addr_pkg::OFF_PREINC_ALIAS)
      |-> mem_req.addr == ptr_reg + 12'h001)
    else $error("pre-increment write address wrong");

  a_preinc_wstep: assert property (
    @(posedge sys_clk) disable iff (srst)
    (reg_wr && reg_addr == indirect_addr_pkg::OFF_PREINC_ALIAS)
      |=> ptr_reg == $past(ptr_reg) + 12'h001)
    else $error("pre-increment write did not step the pointer");

  a_plain_hold: assert property (
    @(posedge sys_clk) disable iff (srst)
    (reg_rd && reg_addr == indirect_addr_pkg::OFF_PLAIN_ALIAS)
      |-> mem_req.addr == ptr_reg ##1 $stable(ptr_reg))
    else $error("plain alias moved the pointer");

  a_plain_whold: assert property (
    @(posedge sys_clk) disable iff (srst)
    (reg_wr && reg_addr == indirect_addr_pkg::OFF_PLAIN_ALIAS)
      |-> mem_req.addr == ptr_reg ##1 $stable(ptr_reg))
    else $error("plain alias write moved the pointer");

  a_offset_addr: assert property (
    @(posedge sys_clk) disable iff (srst)
    (mem_req.wr && reg_addr == indirect_addr_pkg::OFF_OFFSET_ALIAS)
      |-> mem_req.addr == ptr_reg + {4'h0, work_reg})
    else $error("offset alias address wrong");

  a_offset_raddr: assert property (
    @(posedge sys_clk) disable iff (srst)
    (mem_req.rd && reg_addr == indirect_addr_pkg::OFF_OFFSET_ALIAS)
      |-> mem_req.addr == ptr_reg + {4'h0, work_reg})
    else $error("offset alias read address wrong");

  a_offset_hold: assert property (
    @(posedge sys_clk) disable iff (srst)
    ((reg_rd || reg_wr) && reg_addr == indirect_addr_pkg::OFF_OFFSET_ALIAS)
      |=> $stable(ptr_reg))
    else $error("offset alias moved the pointer");

  // Aliases carry nothing of their own: reads come from memory, writes go
  // to memory, and no other offset may reach the memory port.
  a_alias_route: assert property (
    @(posedge sys_clk) disable iff (srst)
    (reg_rd && alias_hit)
      |=> reg_rdata == mem_rdata)
    else $error("alias read not taken from memory");

  a_no_stray_req: assert property (
    @(posedge sys_clk) disable iff (srst)
    (!alias_hit)
      |-> !mem_req.rd && !mem_req.wr)
    else $error("memory request from a non-alias offset");

  a_wdata_pass: assert property (
    @(posedge sys_clk) disable iff (srst)
    (mem_req.wr)
      |-> mem_req.wdata == reg_wdata)
    else $error("alias write data not passed to memory");

  a_ptr_quiet: assert property (
    @(posedge sys_clk) disable iff (srst)
    (!reg_rd && !reg_wr)
      |=> $stable(ptr_reg))
    else $error("pointer moved without an access");

  a_high_nibble: assert property (
    @(posedge sys_clk) disable iff (srst)
    (reg_rd && reg_addr == indirect_addr_pkg::OFF_POINTER_TWO_HI)
      |=> reg_rdata[7:4] == 4'h0 && reg_rdata[3:0] == $past(ptr_reg[11:8]))
    else $error("pointer high byte read wrong");

  a_high_write: assert property (
    @(posedge sys_clk) disable iff (srst)
    (reg_wr && reg_addr == indirect_addr_pkg::OFF_POINTER_TWO_HI)
      |=> ptr_reg[11:8] == $past(reg_wdata[3:0]) && ptr_reg[7:0] == $past(ptr_reg[7:0]))
    else $error("pointer high byte not written");

  a_low_write: assert property (
    @(posedge sys_clk) disable iff (srst)
    (reg_wr && reg_addr == indirect_addr_pkg::OFF_POINTER_TWO_LO)
      |=> ptr_reg[7:0] == $past(reg_wdata) && ptr_reg[11:8] == $past(ptr_reg[11:8]))
    else $error("pointer low byte not written");

  a_low_read: assert property (
    @(posedge sys_clk) disable iff (srst)
    (reg_rd && reg_addr == indirect_addr_pkg::OFF_POINTER_TWO_LO)
      |=> reg_rdata == $past(ptr_reg[7:0]))
    else $error("pointer low byte read wrong");

  a_ptr1_write: assert property (
    @(posedge sys_clk) disable iff (srst)
    (reg_wr && reg_addr == indirect_addr_pkg::OFF_POINTER_ONE_LOW)
      |=> ptr1_reg == $past(reg_wdata))
    else $error("first pointer low byte not written");

  a_ptr1_read: assert property (
    @(posedge sys_clk) disable iff (srst)
    (reg_rd && reg_addr == indirect_addr_pkg::OFF_POINTER_ONE_LOW)
      |=> reg_rdata == $past(ptr1_reg))
    else $error("first pointer low byte read wrong");

  // Reset is checked without a disable, since reset itself is the trigger.
  a_bank_reset: assert property (
    @(posedge sys_clk)
    srst
      |=> bank_sel == 4'h0)
    else $error("bank select not cleared");

  a_bank_write: assert property (
    @(posedge sys_clk) disable iff (srst)
    (reg_wr && reg_addr == indirect_addr_pkg::OFF_BANK_SELECT)
      |=> bank_sel == $past(reg_wdata[3:0]))
    else $error("bank select not written");

  a_bank_read: assert property (
    @(posedge sys_clk) disable iff (srst)
    (reg_rd && reg_addr == indirect_addr_pkg::OFF_BANK_SELECT)
      |=> reg_rdata == {4'h0, $past(bank_sel)})
    else $error("bank select read wrong");

  // The three wrap checks cover both ends of the twelve-bit range; a carry
  // that stopped at the low byte would break each of them.
  a_wrap_top: assert property (
    @(posedge sys_clk) disable iff (srst)
    (reg_rd && reg_addr == indirect_addr_pkg::OFF_POSTINC_ALIAS && ptr_reg == 12'hfff)
      |=> ptr_reg == 12'h000)
    else $error("pointer did not wrap");

  a_wrap_bottom: assert property (
    @(posedge sys_clk) disable iff (srst)
    ((reg_rd || reg_wr) && reg_addr == indirect_addr_pkg::OFF_POSTDEC_ALIAS && ptr_reg == 12'h000)
      |=> ptr_reg == 12'hfff)
    else $error("pointer did not wrap downwards");

  a_preinc_wrap: assert property (
    @(posedge sys_clk) disable iff (srst)
    ((mem_req.rd || mem_req.wr) && reg_addr == indirect_addr_pkg::OFF_PREINC_ALIAS
      && ptr_reg == 12'hfff)
      |-> mem_req.addr == 12'h000)
    else $error("pre-increment address did not wrap");

endmodule

// ==== hdl/indirect_addr_pkg.sv ====
package indirect_addr_pkg;

  // Register offsets on the plain register port.
  localparam logic [3:0] OFF_POINTER_ONE_LOW = 4'h0;
  localparam logic [3:0] OFF_BANK_SELECT     = 4'h1;
  localparam logic [3:0] OFF_PLAIN_ALIAS     = 4'h2;
  localparam logic [3:0] OFF_POSTINC_ALIAS   = 4'h3;
  localparam logic [3:0] OFF_POSTDEC_ALIAS   = 4'h4;
  localparam logic [3:0] OFF_PREINC_ALIAS    = 4'h5;
  localparam logic [3:0] OFF_OFFSET_ALIAS    = 4'h6;
  localparam logic [3:0] OFF_POINTER_TWO_HI  = 4'h7;
  localparam logic [3:0] OFF_POINTER_TWO_LO  = 4'h8;

  localparam int         ADDR_W           = 12;
  localparam int         HIGH_W           = 4;
  localparam logic [3:0] BANK_RESET       = 4'h0;
  localparam logic [7:0] POINTER_RESET    = 8'h00;

  typedef enum logic [2:0] {
    MODE_PLAIN   = 3'h0,
    MODE_POSTINC = 3'h1,
    MODE_POSTDEC = 3'h3,
    MODE_PREINC  = 3'h2,
    MODE_OFFSET  = 3'h6
  } alias_mode_e;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } mem_req_s;

endpackage

// ==== verification/data_mem_model.sv ====
`timescale 1ns/100ps
module data_mem_model (
  input  wire logic                  sys_clk,
  input  indirect_addr_pkg::mem_req_s mem_req,
  output logic [7:0]                 mem_rdata
);
  logic [7:0]  store [0:4095];
  logic        answer_reg;
  logic [11:0] addr_reg;
  always_ff @(posedge sys_clk) begin
    answer_reg <= mem_req.rd;
    addr_reg <= mem_req.addr;
    if (mem_req.wr) begin
      store[mem_req.addr] <= mem_req.wdata;
    end
  end
  // Outside the answer cycle the line shows the inverse, so a late sample never matches.
  assign mem_rdata = answer_reg ? store[addr_reg] : ~store[addr_reg];
endmodule

// ==== verification/test_indirect_data_addressing.sv ====
`timescale 1ns/100ps
module test_indirect_data_addressing;
  logic                        sys_clk, srst, reg_wr, reg_rd, w, rd_dly, acc_dly;
  logic [3:0]                  reg_addr, off, bank_sel;
  logic [7:0]                  reg_wdata, reg_rdata, work_reg, mem_rdata, wv, d;
  logic [11:0]                 pointer_two, ptr, a;
  indirect_addr_pkg::mem_req_s mem_req;
  logic [7:0]                  shadow [0:4095];
  bit                          known [0:4095];
  logic [11:0]                 exp_data [$], exp_ptr [$], exp_addr [$];
  int                          n_mismatch, total_checks;
  indirect_data_addressing dut_u (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .work_reg(work_reg), .mem_req(mem_req), .mem_rdata(mem_rdata), .bank_sel(bank_sel),
    .pointer_two(pointer_two));
  data_mem_model mem_u (.sys_clk(sys_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic check(input string nm, input logic [11:0] e, input logic [11:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Strobes stay up between back-to-back accesses, so no signal is driven twice per edge.
  task automatic acc(input logic wr, input logic [3:0] ad, input logic [7:0] dv);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= ad;
    reg_wdata <= dv;
    exp_ptr.push_back(ptr);
    @(posedge sys_clk);
  endtask
  task automatic read_expect(input logic [3:0] ad, input logic [7:0] e);
    exp_data.push_back({4'h0, e});
    acc(1'b0, ad, 8'h00);
  endtask
  always @(negedge sys_clk) begin
    if (rd_dly) check("reg_rdata", exp_data.pop_front(), {4'h0, reg_rdata});
    if (acc_dly) check("pointer_two", exp_ptr.pop_front(), pointer_two);
    if (mem_req.rd | mem_req.wr) check("mem_addr", exp_addr.pop_front(), mem_req.addr);
    rd_dly = reg_rd;
    acc_dly = reg_rd | reg_wr;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {srst, reg_wr, reg_rd, reg_addr, reg_wdata, work_reg} = {1'b1, 22'h0};
    {rd_dly, acc_dly, ptr, n_mismatch, total_checks} = '0;
    void'($urandom(20));
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    check("bank_sel", 12'h000, {8'h00, bank_sel});
    read_expect(indirect_addr_pkg::OFF_BANK_SELECT, 8'h00);
    acc(1'b1, indirect_addr_pkg::OFF_BANK_SELECT, 8'hab);
    read_expect(indirect_addr_pkg::OFF_BANK_SELECT, 8'h0b);
    check("bank_sel", 12'h00b, {8'h00, bank_sel});
    acc(1'b1, indirect_addr_pkg::OFF_POINTER_ONE_LOW, 8'h5a);
    read_expect(indirect_addr_pkg::OFF_POINTER_ONE_LOW, 8'h5a);
    read_expect(4'hf, 8'h00);
    ptr = 12'hf00;
    acc(1'b1, indirect_addr_pkg::OFF_POINTER_TWO_HI, 8'hff);
    ptr = 12'hffe;
    acc(1'b1, indirect_addr_pkg::OFF_POINTER_TWO_LO, 8'hfe);
    read_expect(indirect_addr_pkg::OFF_POINTER_TWO_HI, 8'h0f);
    read_expect(indirect_addr_pkg::OFF_POINTER_TWO_LO, 8'hfe);
    for (int i = 0; i < 300; i++) begin
      off = 4'h2 + 4'($urandom_range(4));
      w = 1'($urandom_range(1));
      wv = 8'($urandom);
      d = 8'($urandom);
      work_reg <= wv;
      if (off == 4'h5) ptr = ptr + 12'h001;
      a = (off == 4'h6) ? ptr + {4'h0, wv} : ptr;
      if (off == 4'h3) ptr = ptr + 12'h001;
      if (off == 4'h4) ptr = ptr - 12'h001;
      if (!known[a]) w = 1'b1;
      exp_addr.push_back(a);
      if (w) begin
        shadow[a] = d;
        known[a] = 1'b1;
      end else begin
        exp_data.push_back({4'h0, shadow[a]});
      end
      acc(w, off, d);
    end
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("queues", 12'h000, 12'(exp_data.size() + exp_ptr.size() + exp_addr.size()));
    end_of_test();
  end
endmodule
